// File: hw/rim_raw_rx.v
// raw input mode receive port: mode strap, config registers, sync-to-packet builder
`timescale 1ns/100ps
`default_nettype none
`include "rim_defs.vh"

module rim_raw_rx #(
    parameter [19:0] STRAP_WAIT_CYCLES = `RIM_STRAP_WAIT_CYC
) (
    input  wire        clk_in,
    input  wire        reset_in,
    input  wire        power_down_bar_in,
    input  wire [2:0]  mode_strap_in,
    input  wire        ref_clock_good_in,
    input  wire [7:0]  reg_addr_in,
    input  wire        reg_wr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_rd_in,
    output reg  [7:0]  reg_rdata_out,
    input  wire        pix_valid_in,
    input  wire [11:0] pix_data_in,
    input  wire        hsync_in,
    input  wire        vsync_in,
    output reg         pix_ready_out,
    output wire        pkt_valid_out,
    output wire [2:0]  pkt_kind_out,
    output wire [1:0]  pkt_vc_out,
    output wire [5:0]  pkt_dt_out,
    output wire [11:0] pkt_data_out,
    input  wire        pkt_ready_in,
    output reg  [2:0]  strap_code_out,
    output reg         strap_done_out,
    output reg         clk_sel_ext_out
);
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_DONE = 3'b100;

    reg [2:0]  st_r;
    reg [19:0] wait_cnt_r;
    reg [7:0]  cfg_r;
    reg [1:0]  vc_r;
    reg [5:0]  dt_r;
    reg        h_r;
    reg        v_r;
    reg [4:0]  pend_r;
    reg [4:0]  pend_nxt;
    reg [11:0] pix_hold_r;
    reg [5:0]  pix_dt_r;
    reg [11:0] pix_fmt;
    reg [5:0]  pix_dt_auto;
    reg [2:0]  emit_kind;
    reg [5:0]  emit_dt;
    reg [4:0]  emit_bit;
    reg        strap_load;
    reg [7:0]  strap_cfg;

    wire [1:0] mode     = cfg_r[`RIM_CFG_MODE_MSB:`RIM_CFG_MODE_LSB];
    wire       raw_mode = (mode != `RIM_MODE_CSI2);
    wire       accept   = pix_valid_in & pix_ready_out;
    wire       buf_ready;

    ////////////////////////////////////////////////////////////////////////
    // strap capture after power-down release

    // selections 5 to 7 are undefined; fall back to csi-2 async input
    always @* begin
        strap_cfg = `RIM_CFG_RESET;
        case (mode_strap_in)
            `RIM_STRAP_TWELVE_LF: strap_cfg[1:0] = `RIM_MODE_TWELVE_SLOW;
            `RIM_STRAP_TWELVE_HF: strap_cfg[1:0] = `RIM_MODE_TWELVE_FAST;
            `RIM_STRAP_TEN:       strap_cfg[1:0] = `RIM_MODE_TEN;
            `RIM_STRAP_CSI2_SYNC: strap_cfg[`RIM_CFG_SYNC_BC_BIT] = 1'b1;
            default:              strap_cfg[1:0] = `RIM_MODE_CSI2;
        endcase
    end

    always @* begin
        strap_load = (st_r == ST_WAIT) && power_down_bar_in &&
                     (wait_cnt_r == STRAP_WAIT_CYCLES - 20'd1);
    end

    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_r           <= ST_IDLE;
            wait_cnt_r     <= 20'h00000;
            strap_code_out <= 3'h0;
            strap_done_out <= 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    wait_cnt_r <= 20'h00000;
                    if (power_down_bar_in) begin
                        st_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    wait_cnt_r <= wait_cnt_r + 20'h00001;
                    if (!power_down_bar_in) begin
                        st_r <= ST_IDLE;
                    end else if (strap_load) begin
                        st_r           <= ST_DONE;
                        strap_code_out <= mode_strap_in;
                        strap_done_out <= 1'b1;
                    end
                end
                ST_DONE: begin
                    // stay here so the strap is sampled only once per release
                    if (!power_down_bar_in) begin
                        st_r           <= ST_IDLE;
                        strap_done_out <= 1'b0;
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // backup oscillator until the reference is usable; the select moves once,
    // and only after the strap is settled, so the clock mux sees one clean change
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            clk_sel_ext_out <= 1'b0;
        end else if (ref_clock_good_in && (st_r == ST_DONE)) begin
            clk_sel_ext_out <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cfg_r <= `RIM_CFG_RESET;
            vc_r  <= `RIM_VC_RESET;
            dt_r  <= `RIM_DT_RESET;
        end else begin
            // strap load wins over a write landing in the same cycle
            if (strap_load) begin
                cfg_r <= strap_cfg;
            end else if (reg_wr_in && (reg_addr_in == `RIM_ADDR_PORT_CFG)) begin
                cfg_r <= {3'h0, reg_wdata_in[4:0]};
            end
            if (reg_wr_in && (reg_addr_in == `RIM_ADDR_VC)) begin
                vc_r <= reg_wdata_in[1:0];
            end
            if (reg_wr_in && (reg_addr_in == `RIM_ADDR_DT)) begin
                dt_r <= reg_wdata_in[5:0];
            end
        end
    end

    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `RIM_ADDR_PORT_CFG: reg_rdata_out <= cfg_r;
                `RIM_ADDR_VC:       reg_rdata_out <= {6'h00, vc_r};
                `RIM_ADDR_DT:       reg_rdata_out <= {2'h0, dt_r};
                default:            reg_rdata_out <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pixel formatting

    always @* begin
        pix_fmt     = pix_data_in;
        pix_dt_auto = `RIM_DT_RAW12;
        if (mode == `RIM_MODE_TEN) begin
            pix_fmt     = {2'h0, pix_data_in[9:0]};
            pix_dt_auto = `RIM_DT_RAW10;
            if (cfg_r[`RIM_CFG_RAW8_BIT]) begin
                pix_dt_auto = `RIM_DT_RAW8;
                if (cfg_r[`RIM_CFG_MSB_ALN_BIT]) begin
                    pix_fmt = {4'h0, pix_data_in[9:2]};
                end else begin
                    pix_fmt = {4'h0, pix_data_in[7:0]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sync edges to packet events; order per sample: LE, FE, FS, LS, pixel

    always @* begin
        emit_bit  = 5'h00;
        emit_kind = `RIM_KIND_PIX;
        emit_dt   = pix_dt_r;
        if (pend_r[0]) begin
            emit_bit  = 5'h01;
            emit_kind = `RIM_KIND_LE;
            emit_dt   = `RIM_DT_LE;
        end else if (pend_r[1]) begin
            emit_bit  = 5'h02;
            emit_kind = `RIM_KIND_FE;
            emit_dt   = `RIM_DT_FE;
        end else if (pend_r[2]) begin
            emit_bit  = 5'h04;
            emit_kind = `RIM_KIND_FS;
            emit_dt   = `RIM_DT_FS;
        end else if (pend_r[3]) begin
            emit_bit  = 5'h08;
            emit_kind = `RIM_KIND_LS;
            emit_dt   = `RIM_DT_LS;
        end else if (pend_r[4]) begin
            emit_bit  = 5'h10;
        end
    end

    always @* begin
        pend_nxt = pend_r;
        if (buf_ready) begin
            pend_nxt = pend_r & ~emit_bit;
        end
        // csi-2 input mode: samples are taken and dropped, no packets built
        if (accept && raw_mode) begin
            pend_nxt[0] = h_r & ~hsync_in;
            pend_nxt[1] = v_r & ~vsync_in;
            pend_nxt[2] = ~v_r & vsync_in;
            pend_nxt[3] = ~h_r & hsync_in & vsync_in;
            pend_nxt[4] = hsync_in & vsync_in;
        end
    end

    // one sample at a time keeps the throughput at one event-producing sample per two cycles at best,
    // but a stalled receiver can never drop an event
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pend_r        <= 5'h00;
            h_r           <= 1'b0;
            v_r           <= 1'b0;
            pix_hold_r    <= 12'h000;
            pix_dt_r      <= 6'h00;
            pix_ready_out <= 1'b0;
        end else begin
            pend_r        <= pend_nxt;
            pix_ready_out <= (pend_nxt == 5'h00);
            if (accept) begin
                h_r        <= hsync_in;
                v_r        <= vsync_in;
                pix_hold_r <= pix_fmt;
                pix_dt_r   <= (dt_r != 6'h00) ? dt_r : pix_dt_auto;
            end
        end
    end

    rim_buf2 #(
        .W(23)
    ) u_buf (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .in_valid_in   (pend_r != 5'h00),
        .in_data_in    ({emit_kind, vc_r, emit_dt, pix_hold_r}),
        .in_ready_out  (buf_ready),
        .out_valid_out (pkt_valid_out),
        .out_data_out  ({pkt_kind_out, pkt_vc_out, pkt_dt_out, pkt_data_out}),
        .out_ready_in  (pkt_ready_in)
    );
endmodule

`default_nettype wire

// File: pkg/rim_defs.vh
// constants for the raw input mode receive port
`ifndef RIM_DEFS_VH
`define RIM_DEFS_VH

// register offsets
`define RIM_ADDR_PORT_CFG    8'h6d
`define RIM_ADDR_VC          8'h70
`define RIM_ADDR_DT          8'h71

// port_input_config fields
`define RIM_CFG_MODE_LSB     0
`define RIM_CFG_MODE_MSB     1
`define RIM_CFG_SYNC_BC_BIT  2
`define RIM_CFG_RAW8_BIT     3
`define RIM_CFG_MSB_ALN_BIT  4
`define RIM_CFG_RESET        8'h00
`define RIM_VC_RESET         2'h0
`define RIM_DT_RESET         6'h00

// rx_input_mode_field encodings
`define RIM_MODE_CSI2        2'h0
`define RIM_MODE_TWELVE_SLOW 2'h1
`define RIM_MODE_TWELVE_FAST 2'h2
`define RIM_MODE_TEN         2'h3

// strap selections
`define RIM_STRAP_CSI2_ASYNC 3'h0
`define RIM_STRAP_TWELVE_LF  3'h1
`define RIM_STRAP_TWELVE_HF  3'h2
`define RIM_STRAP_TEN        3'h3
`define RIM_STRAP_CSI2_SYNC  3'h4

// csi-2 data types
`define RIM_DT_FS            6'h00
`define RIM_DT_FE            6'h01
`define RIM_DT_LS            6'h02
`define RIM_DT_LE            6'h03
`define RIM_DT_RAW8          6'h2a
`define RIM_DT_RAW10         6'h2b
`define RIM_DT_RAW12         6'h2c

// output word kinds
`define RIM_KIND_FS          3'h0
`define RIM_KIND_FE          3'h1
`define RIM_KIND_LS          3'h2
`define RIM_KIND_LE          3'h3
`define RIM_KIND_PIX         3'h4

// timing
`define RIM_CLK_MHZ          250
`define RIM_STRAP_WAIT_US    1000
// 1 ms at 250 MHz, sized to the 20-bit wait counter
`define RIM_STRAP_WAIT_CYC   20'd250000

`endif

// File: hw/rim_buf2.v
// two-entry valid/ready buffer with registered outputs
`timescale 1ns/100ps
`default_nettype none

module rim_buf2 #(
    parameter W = 23
) (
    input  wire         clk_in,
    input  wire         reset_in,
    input  wire         in_valid_in,
    input  wire [W-1:0] in_data_in,
    output wire         in_ready_out,
    output wire         out_valid_out,
    output wire [W-1:0] out_data_out,
    input  wire         out_ready_in
);
    reg [W-1:0] q0_r;
    reg [W-1:0] q1_r;
    reg         v0_r;
    reg         v1_r;
    wire        push;
    wire        pop;

    // ready is the inverse of the second slot: a flop, no comb path from out_ready
    assign in_ready_out  = ~v1_r;
    assign out_valid_out = v0_r;
    assign out_data_out  = q0_r;
    assign push = in_valid_in & ~v1_r;
    assign pop  = out_ready_in & v0_r;

    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            q0_r <= {W{1'b0}};
            q1_r <= {W{1'b0}};
            v0_r <= 1'b0;
            v1_r <= 1'b0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (!v0_r) begin
                        q0_r <= in_data_in;
                        v0_r <= 1'b1;
                    end else begin
                        q1_r <= in_data_in;
                        v1_r <= 1'b1;
                    end
                end
                2'b01: begin
                    if (v1_r) begin
                        q0_r <= q1_r;
                        v1_r <= 1'b0;
                    end else begin
                        v0_r <= 1'b0;
                    end
                end
                2'b11: begin
                    if (v1_r) begin
                        q0_r <= q1_r;
                        q1_r <= in_data_in;
                    end else begin
                        q0_r <= in_data_in;
                    end
                end
                default: begin
                    q0_r <= q0_r;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// File: testbench/rim_raw_rx_checker.sv
// assertions on the ports of the raw input receive port
`timescale 1ns/100ps
`default_nettype none
`include "rim_defs.vh"
module rim_raw_rx_checker #(
    parameter [19:0] STRAP_WAIT_CYCLES = `RIM_STRAP_WAIT_CYC
) (
    input wire        clk_in,
    input wire        reset_in,
    input wire        power_down_bar_in,
    input wire        ref_clock_good_in,
    input wire [7:0]  reg_addr_in,
    input wire        reg_rd_in,
    input wire [7:0]  reg_rdata_out,
    input wire        pkt_valid_out,
    input wire [2:0]  pkt_kind_out,
    input wire [5:0]  pkt_dt_out,
    input wire [11:0] pkt_data_out,
    input wire        pkt_ready_in,
    input wire [2:0]  strap_code_out,
    input wire        strap_done_out,
    input wire        clk_sel_ext_out
);
default clocking @(posedge clk_in); endclocking
default disable iff (reset_in);
////////////////////////////////////////////////////////////////////////////////
// edges seen with power_down_bar_in high since it last went low
reg [19:0] high_cnt_r;
always @(posedge clk_in or posedge reset_in) begin
    if (reset_in)
        high_cnt_r <= 20'h0;
    else if (!power_down_bar_in)
        high_cnt_r <= 20'h0;
    else if (high_cnt_r != 20'hfffff)
        high_cnt_r <= high_cnt_r + 20'h1;
end
////////////////////////////////////////////////////////////////////////////////
property p_strap_wait;
    $rose(strap_done_out) |-> high_cnt_r >= STRAP_WAIT_CYCLES - 20'h1;
endproperty
a_strap_wait: assert property (p_strap_wait) else $error("strap taken early");
property p_strap_hold;
    strap_done_out && power_down_bar_in |=> strap_done_out && $stable(strap_code_out);
endproperty
a_strap_hold: assert property (p_strap_hold) else $error("strap resampled");
property p_strap_clear;
    !power_down_bar_in |-> ##1 !strap_done_out;
endproperty
a_strap_clear: assert property (p_strap_clear) else $error("done kept in power down");
property p_clk_switch;
    ref_clock_good_in && strap_done_out |=> clk_sel_ext_out;
endproperty
a_clk_switch: assert property (p_clk_switch) else $error("no switch to reference");
property p_clk_sticky;
    clk_sel_ext_out |=> clk_sel_ext_out;
endproperty
a_clk_sticky: assert property (p_clk_sticky) else $error("clock select dropped");
property p_backup_first;
    $rose(clk_sel_ext_out) |-> $past(ref_clock_good_in) && $past(strap_done_out);
endproperty
a_backup_first: assert property (p_backup_first) else $error("left backup early");
property p_out_hold;
    pkt_valid_out && !pkt_ready_in |=> pkt_valid_out
        && $stable({pkt_kind_out, pkt_dt_out, pkt_data_out});
endproperty
a_out_hold: assert property (p_out_hold) else $error("word lost on stall");
property p_short_dt;
    pkt_valid_out && pkt_kind_out != `RIM_KIND_PIX |-> pkt_dt_out == {3'h0, pkt_kind_out};
endproperty
a_short_dt: assert property (p_short_dt) else $error("sync packet type wrong");
property p_unmapped;
    reg_rd_in && reg_addr_in != `RIM_ADDR_PORT_CFG && reg_addr_in != `RIM_ADDR_VC
        && reg_addr_in != `RIM_ADDR_DT |=> reg_rdata_out == 8'h00;
endproperty
a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind rim_raw_rx rim_raw_rx_checker #(.STRAP_WAIT_CYCLES(STRAP_WAIT_CYCLES)) u_chk (
    .clk_in(clk_in), .reset_in(reset_in), .power_down_bar_in(power_down_bar_in),
    .ref_clock_good_in(ref_clock_good_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .pkt_valid_out(pkt_valid_out),
    .pkt_kind_out(pkt_kind_out), .pkt_dt_out(pkt_dt_out), .pkt_data_out(pkt_data_out),
    .pkt_ready_in(pkt_ready_in), .strap_code_out(strap_code_out),
    .strap_done_out(strap_done_out), .clk_sel_ext_out(clk_sel_ext_out));
`default_nettype wire

// File: testbench/rim_src_model.sv
// pixel source standing in for the remote serializer
`timescale 1ns/100ps
`default_nettype none
module rim_src_model #(
    parameter SYNC_GAP = 10
) (
    input  wire        clk_in,
    input  wire        pix_ready_in,
    input  wire        ten_mode_in,
    output reg         pix_valid_out,
    output reg  [11:0] pix_data_out,
    output reg         hsync_out,
    output reg         vsync_out
);
integer cyc = 0;
integer last_chg = -100;
initial begin
    pix_valid_out = 1'b0;
    pix_data_out = 12'h5a5;
    hsync_out = 1'b0;
    vsync_out = 1'b0;
end
always @(posedge clk_in) cyc <= cyc + 1;
task send(input h, input v, input [11:0] d);
    reg ok;
    begin
        @(negedge clk_in);
        // spacing in ten-bit mode, setup before any line opens
        while ((h !== hsync_out || v !== vsync_out) && (ten_mode_in || (h && !hsync_out))
               && cyc - last_chg < SYNC_GAP) begin
            pix_valid_out = 1'b0;
            pix_data_out = ~pix_data_out;
            @(negedge clk_in);
        end
        if (h !== hsync_out || v !== vsync_out)
            last_chg = cyc;
        hsync_out = h;
        vsync_out = v;
        pix_valid_out = 1'b1;
        pix_data_out = d;
        ok = pix_ready_in;
        @(posedge clk_in);
        while (!ok) begin
            @(negedge clk_in);
            ok = pix_ready_in;
            @(posedge clk_in);
        end
    end
endtask
task idle;
    begin
        @(negedge clk_in);
        pix_valid_out = 1'b0;
        pix_data_out = ~pix_data_out;
    end
endtask
endmodule
`default_nettype wire

// File: testbench/rim_raw_rx_test.sv
// self-checking bench for the raw input receive port
`timescale 1ns/100ps
`default_nettype none
`include "rim_defs.vh"
module rim_raw_rx_test;
reg        clk_in = 1'b0;
reg        reset_in = 1'b1;
reg        power_down_bar = 1'b1;
reg  [2:0] strap = 3'h3;
reg        ref_clock_good = 1'b0;
reg  [7:0] addr = 8'h0;
reg  [7:0] wdata = 8'h0;
reg        wr = 1'b0;
reg        rd = 1'b0;
reg        pkt_ready = 1'b0;
reg        stall = 1'b1;
wire [7:0] rdata;
wire [11:0] pix_data, pkt_data;
wire [2:0] kind, strap_code;
wire [1:0] vc;
wire [5:0] dt;
wire       pix_valid, hsync, vsync, pix_ready, pkt_valid, strap_done, clk_sel;
integer    mismatches = 0;
integer    checks = 0;
integer    s, m;
reg [31:0] seed = 32'd22;
reg [7:0]  cfg;
reg [1:0]  vc_r;
reg [5:0]  dt_r;
reg        ph = 1'b0;
reg        pv = 1'b0;
reg [22:0] expq[$];
reg [22:0] gotq[$];
reg [7:0]  cfgs [0:5] = '{8'h01, 8'h02, 8'h03, 8'h0b, 8'h1b, 8'h00};
always #2 clk_in = ~clk_in;
rim_raw_rx #(.STRAP_WAIT_CYCLES(20'd8)) u_dut (
    .clk_in(clk_in), .reset_in(reset_in), .power_down_bar_in(power_down_bar),
    .mode_strap_in(strap), .ref_clock_good_in(ref_clock_good), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .pix_valid_in(pix_valid), .pix_data_in(pix_data),
    .hsync_in(hsync), .vsync_in(vsync), .pix_ready_out(pix_ready), .pkt_valid_out(pkt_valid),
    .pkt_kind_out(kind), .pkt_vc_out(vc), .pkt_dt_out(dt), .pkt_data_out(pkt_data),
    .pkt_ready_in(pkt_ready), .strap_code_out(strap_code), .strap_done_out(strap_done),
    .clk_sel_ext_out(clk_sel));
rim_src_model u_src (
    .clk_in(clk_in), .pix_ready_in(pix_ready), .ten_mode_in(cfg[1:0] == 2'h3),
    .pix_valid_out(pix_valid), .pix_data_out(pix_data), .hsync_out(hsync), .vsync_out(vsync));
////////////////////////////////////////////////////////////////////////////////
function [31:0] rnd;
    input dummy;
    begin
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed;
    end
endfunction
function [22:0] word(input [2:0] k, input [11:0] d);
    reg [5:0]  pdt;
    reg [11:0] pd;
    begin
        pdt = dt_r != 6'h0 ? dt_r : cfg[1:0] != 2'h3 ? `RIM_DT_RAW12
            : cfg[3] ? `RIM_DT_RAW8 : `RIM_DT_RAW10;
        pd = cfg[1:0] != 2'h3 ? d : !cfg[3] ? {2'h0, d[9:0]}
            : cfg[4] ? {4'h0, d[9:2]} : {4'h0, d[7:0]};
        word = k == `RIM_KIND_PIX ? {k, vc_r, pdt, pd} : {k, vc_r, 3'h0, k, 12'h0};
    end
endfunction
// receiver stalls at random so the buffer sees back pressure
always @(negedge clk_in) pkt_ready <= !stall && (rnd(0) % 3 != 0);
always @(posedge clk_in)
    if (pkt_valid && pkt_ready)
        gotq.push_back({kind, vc, dt, kind == `RIM_KIND_PIX ? pkt_data : 12'h0});
////////////////////////////////////////////////////////////////////////////////
task check(input string n, input [22:0] seen, input [22:0] exp);
    begin
        checks = checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    end
endtask
task finish_test;
    begin
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
endtask
task wreg(input [7:0] a, input [7:0] d);
    begin
        @(negedge clk_in);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_in);
        wr = 1'b0;
    end
endtask
task rreg(input [7:0] a, input [7:0] exp);
    begin
        @(negedge clk_in);
        addr = a;
        rd = 1'b1;
        @(negedge clk_in);
        rd = 1'b0;
        check("rdata", {15'h0, rdata}, {15'h0, exp});
    end
endtask
task restrap(input [2:0] c);
    integer i;
    begin
        @(negedge clk_in);
        power_down_bar = 1'b0;
        strap = c;
        @(negedge clk_in);
        power_down_bar = 1'b1;
        for (i = 0; i < 40 && strap_done !== 1'b1; i = i + 1)
            @(negedge clk_in);
        check("strap", {20'h0, strap_code}, {20'h0, c});
        rreg(`RIM_ADDR_PORT_CFG, c < 3'h5 ? {5'h0, c} : 8'h00);
    end
endtask
task pix(input h, input v);
    reg [11:0] d;
    begin
        d = rnd(0);
        u_src.send(h, v, d);
        if (cfg[1:0] != `RIM_MODE_CSI2) begin
            if (ph && !h) expq.push_back(word(`RIM_KIND_LE, d));
            if (pv && !v) expq.push_back(word(`RIM_KIND_FE, d));
            if (!pv && v) expq.push_back(word(`RIM_KIND_FS, d));
            if (!ph && h && v) expq.push_back(word(`RIM_KIND_LS, d));
            if (h && v) expq.push_back(word(`RIM_KIND_PIX, d));
        end
        ph = h;
        pv = v;
    end
endtask
task frame;
    integer l, p;
    begin
        pix(1'b0, 1'b1);
        for (l = 0; l < 2; l = l + 1) begin
            for (p = 0; p < 3; p = p + 1)
                pix(1'b1, 1'b1);
            pix(1'b0, 1'b1);
        end
        pix(1'b0, 1'b0);
        u_src.idle;
    end
endtask
task drain;
    integer i;
    begin
        for (i = 0; i < 400 && gotq.size() < expq.size(); i = i + 1)
            @(negedge clk_in);
        repeat (10) @(negedge clk_in);
        check("count", 23'(gotq.size()), 23'(expq.size()));
        while (expq.size() > 0 && gotq.size() > 0)
            check("word", gotq.pop_front(), expq.pop_front());
        expq.delete();
        gotq.delete();
    end
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    cfg = 8'h03;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    reset_in = 1'b0;
    restrap(3'h3);
    rreg(`RIM_ADDR_VC, 8'h00);
    rreg(`RIM_ADDR_DT, 8'h00);
    rreg(8'h55, 8'h00);
    wreg(8'h55, 8'haa);
    rreg(8'h55, 8'h00);
    wreg(`RIM_ADDR_PORT_CFG, 8'hff);
    rreg(`RIM_ADDR_PORT_CFG, 8'h1f);
    check("clk_sel", {22'h0, clk_sel}, 23'h0);
    // reference now valid and running without gaps
    ref_clock_good = 1'b1;
    repeat (2) @(negedge clk_in);
    check("clk_sel", {22'h0, clk_sel}, 23'h1);
    for (s = 0; s < 8; s = s + 1)
        restrap(s[2:0]);
    wreg(`RIM_ADDR_PORT_CFG, 8'h01);
    repeat (20) @(negedge clk_in);
    rreg(`RIM_ADDR_PORT_CFG, 8'h01);
    for (m = 0; m < 6; m = m + 1) begin
        cfg = cfgs[m];
        vc_r = rnd(0);
        dt_r = m % 2 ? rnd(0) : 32'h0;
        wreg(`RIM_ADDR_PORT_CFG, cfg);
        wreg(`RIM_ADDR_VC, {6'h0, vc_r});
        wreg(`RIM_ADDR_DT, {2'h0, dt_r});
        stall = 1'b1;
        fork
            frame;
            begin
                repeat (40) @(negedge clk_in);
                if (cfg[1:0] != 2'h0)
                    check("pix_ready", {22'h0, pix_ready}, 23'h0);
                stall = 1'b0;
            end
        join
        drain;
    end
    finish_test;
end
initial begin
    #200000;
    mismatches = mismatches + 1;
    finish_test;
end
endmodule
`default_nettype wire
